// >>> rrlat_defines.vh
// constants for the register-read latency control block
`ifndef RRLAT_DEFINES_VH
`define RRLAT_DEFINES_VH
// apb register byte offsets
`define RRLAT_OFF_CFG3_NV     8'h00
`define RRLAT_OFF_CFG3_V      8'h04
`define RRLAT_OFF_LAT_CODE    8'h08
`define RRLAT_OFF_STATUS      8'h0c
// field positions in config register three
`define RRLAT_BIT_LEGACY_RST  0
`define RRLAT_BIT_SPARE       1
// reset values
`define RRLAT_CFG3_RESET      8'h00
`define RRLAT_LAT_RESET       2'h0
// fixed latency counts in link clock cycles
`define RRLAT_DUMMY_DISCOVER  6'h08
`define RRLAT_DUMMY_UNIQUE_ID 6'h20
// latency code values
`define RRLAT_CODE_00         2'h0
`define RRLAT_CODE_01         2'h1
`define RRLAT_CODE_10         2'h2
`define RRLAT_CODE_11         2'h3
// command classes
`define RRLAT_CLS_FAST        3'h0
`define RRLAT_CLS_REGULAR     3'h1
`define RRLAT_CLS_ADDR        3'h2
`define RRLAT_CLS_ANY_REG     3'h3
`define RRLAT_CLS_DISCOVER    3'h4
`define RRLAT_CLS_UNIQUE_ID   3'h5
// legacy reset opcode
`define RRLAT_OP_LEGACY_RST   8'hf0
`endif

// >>> rrlat_top.v
// register-read latency control with apb registers and link-side counter
// register map, one aligned word each
//   0x00 config_three_nonvolatile: bit 0 legacy_reset_enable, bit 1 spare_bit
//   0x04 config_three_volatile: same layout, bit 0 gates the legacy reset
//   0x08 latency code in bits 1:0
//   0x0c remaining latency count in bits 5:0, read only
// command side
//   cmd_valid is a one-cycle strobe from the opcode decoder on pclk
//   classes: 0 fast, 1 regular, 2 with address, 3 read any register,
//   4 discoverable parameters, 5 unique identifier
//   a command other than the legacy reset opcode during a count restarts the count
// link side
//   link_sck is asynchronous: two flops, then an edge history flop
//   data_ready follows the last counted rise by about three pclk cycles
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rrlat_defines.vh"

module rrlat_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        link_sck,
    input  wire        cmd_valid,
    input  wire [2:0]  cmd_class,
    input  wire [7:0]  cmd_opcode,
    output reg         soft_reset,
    output reg  [5:0]  dummy_count,
    output reg         data_ready
);

    //--------------------------------------------------------------
    // latency decode
    //--------------------------------------------------------------
    // cycles for a class under a latency code
    function [5:0] lat_cycles;
        input [1:0] code;
        input [2:0] cls;
        begin
            case (cls)
                `RRLAT_CLS_DISCOVER:  lat_cycles = `RRLAT_DUMMY_DISCOVER;
                `RRLAT_CLS_UNIQUE_ID: lat_cycles = `RRLAT_DUMMY_UNIQUE_ID;
                default: begin
                    case (code)
                        `RRLAT_CODE_00: lat_cycles = 6'h00;
                        `RRLAT_CODE_01: lat_cycles =
                            (cls == `RRLAT_CLS_FAST) ? 6'h00 : 6'h01;
                        `RRLAT_CODE_10: lat_cycles = 6'h01;
                        default:        lat_cycles = 6'h02;
                    endcase
                end
            endcase
        end
    endfunction

    //--------------------------------------------------------------
    // apb register file
    //--------------------------------------------------------------
    // one-hot register select, all zero for an unmapped offset
    function [3:0] reg_decode;
        input [7:0] addr;
        begin
            case (addr)
                `RRLAT_OFF_CFG3_NV:  reg_decode = 4'h1;
                `RRLAT_OFF_CFG3_V:   reg_decode = 4'h2;
                `RRLAT_OFF_LAT_CODE: reg_decode = 4'h4;
                `RRLAT_OFF_STATUS:   reg_decode = 4'h8;
                default:             reg_decode = 4'h0;
            endcase
        end
    endfunction

    reg  [7:0] cfg3_nv_q;
    reg  [7:0] cfg3_v_q;
    reg  [1:0] lat_code_q;
    reg  [5:0] cnt_q;       // remaining link rises
    reg  [5:0] cnt_d;
    reg        busy_q;      // latency phase in progress
    reg        busy_d;
    reg  [5:0] dummy_d;
    reg        ready_d;
    reg        reset_d;
    wire [3:0] reg_hit;
    wire [5:0] cmd_lat;
    wire       legacy_op;
    wire       legacy_on;
    wire       wr_en = psel & penable & pwrite;
    wire       rd_setup = psel & ~penable & ~pwrite;
    wire       addr_ok;

    // zero wait states, unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign reg_hit = reg_decode(paddr);
    assign addr_ok = |reg_hit;
    assign pslverr = psel & penable & ~addr_ok;

    // register writes, both legacy reset copies reset to zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg3_nv_q  <= `RRLAT_CFG3_RESET;
            cfg3_v_q   <= `RRLAT_CFG3_RESET;
            lat_code_q <= `RRLAT_LAT_RESET;
        end else if (wr_en) begin
            case (paddr)
                `RRLAT_OFF_CFG3_NV:  cfg3_nv_q  <= pwdata[7:0];
                `RRLAT_OFF_CFG3_V:   cfg3_v_q   <= pwdata[7:0];
                `RRLAT_OFF_LAT_CODE: lat_code_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // read data, registered in the setup phase and valid in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `RRLAT_OFF_CFG3_NV:  prdata <= {24'h000000, cfg3_nv_q};
                `RRLAT_OFF_CFG3_V:   prdata <= {24'h000000, cfg3_v_q};
                `RRLAT_OFF_LAT_CODE: prdata <= {30'h00000000, lat_code_q};
                `RRLAT_OFF_STATUS:   prdata <= {26'h0000000, cnt_q};
                default:             prdata <= 32'h00000000;
            endcase
        end
    end

    //--------------------------------------------------------------
    // link clock sampling
    //--------------------------------------------------------------
    reg       sck_s1_q;
    reg       sck_s2_q;
    reg       sck_s3_q;
    wire      sck_rise;

    // rising edge of the synchronised link clock
    assign sck_rise = sck_s2_q & ~sck_s3_q;

    // two-stage synchroniser then edge history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
        end else begin
            sck_s1_q <= link_sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    //--------------------------------------------------------------
    // command handling and dummy counter
    //--------------------------------------------------------------
    // latency for the command on the bus this cycle
    assign cmd_lat   = lat_cycles(lat_code_q, cmd_class);
    assign legacy_op = (cmd_opcode == `RRLAT_OP_LEGACY_RST);
    assign legacy_on = cfg3_v_q[`RRLAT_BIT_LEGACY_RST];

    // next state: a new non-legacy command reloads, link rises count down
    always @* begin
        cnt_d   = cnt_q;
        busy_d  = busy_q;
        dummy_d = dummy_count;
        ready_d = 1'b0;
        reset_d = 1'b0;
        if (cmd_valid) begin
            if (legacy_op) begin
                reset_d = legacy_on;
            end else begin
                dummy_d = cmd_lat;
                cnt_d   = cmd_lat;
                busy_d  = (cmd_lat != 6'h00);
                ready_d = (cmd_lat == 6'h00);
            end
        end else if (busy_q && sck_rise) begin
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
                busy_d  = 1'b0;
                ready_d = 1'b1;
            end
        end
    end

    // command state registers, pulses last one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= 6'h00;
            busy_q      <= 1'b0;
            dummy_count <= 6'h00;
            data_ready  <= 1'b0;
            soft_reset  <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            busy_q      <= busy_d;
            dummy_count <= dummy_d;
            data_ready  <= ready_d;
            soft_reset  <= reset_d;
        end
    end

endmodule
`default_nettype wire

// >>> rrlat_properties.sv
// assertions on the latency control block ports
`timescale 1ns/1ps
`default_nettype none
module rrlat_properties (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       cmd_valid,
    input wire logic       soft_reset,
    input wire logic       data_ready,
    input wire logic [7:0] paddr,
    input wire logic [7:0] cmd_opcode,
    input wire logic [2:0] cmd_class,
    input wire logic [5:0] dummy_count
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // command whose latency came out as zero
    sequence s_zero; (cmd_valid && cmd_opcode != 8'hf0) ##1 (dummy_count == 6'h00); endsequence
    chk_reset_gate: assert property (soft_reset |-> $past(cmd_valid) && $past(cmd_opcode) == 8'hf0)
        else $error("reset without f0");
    chk_reset_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("reset not a pulse");
    chk_sfdp_eight: assert property (cmd_valid && cmd_opcode != 8'hf0 && cmd_class == 3'h4
        |=> dummy_count == 6'h08)
        else $error("sfdp count");
    chk_uid_long: assert property (cmd_valid && cmd_opcode != 8'hf0 && cmd_class == 3'h5
        |=> dummy_count == 6'h20)
        else $error("uid count");
    chk_reg_small: assert property (cmd_valid && cmd_opcode != 8'hf0 && cmd_class < 3'h4
        |=> dummy_count <= 6'h02)
        else $error("register latency");
    chk_zero_ready: assert property (s_zero |-> ##[0:1] data_ready)
        else $error("zero latency late");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h0c |-> pslverr && pready)
        else $error("unmapped access");
endmodule
bind rrlat_top rrlat_properties i_rrlat_properties (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pready      (pready),
    .pslverr     (pslverr),
    .cmd_valid   (cmd_valid),
    .soft_reset  (soft_reset),
    .data_ready  (data_ready),
    .paddr       (paddr),
    .cmd_opcode  (cmd_opcode),
    .cmd_class   (cmd_class),
    .dummy_count (dummy_count)
);
`default_nettype wire

// >>> rrlat_host_model.sv
// host model driving the serial clock in frames
`timescale 1ns/1ps
`default_nettype none
module rrlat_host_model (
    input  wire logic run,
    output var logic  sck
);
    // 64 ns period, still between frames, phase offset from pclk
    initial begin
        sck = 1'b0;
        #1.3;
        forever #32 sck = run ? ~sck : 1'b0;
    end
endmodule
`default_nettype wire

// >>> rrlat_top_tb.sv
// testbench for the register-read latency control block
`timescale 1ns/1ps
`default_nettype none
module rrlat_top_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        cmd_valid = 0, run = 0, er;
    logic [7:0]  paddr = 0, cmd_opcode = 0;
    logic [31:0] pwdata = 0, rd;
    logic [2:0]  cmd_class = 0;
    wire         pready, pslverr, link_sck, soft_reset, data_ready;
    wire  [31:0] prdata;
    wire  [5:0]  dummy_count;
    int          num_errors = 0, n_checks = 0;
    always #2 pclk = ~pclk;
    rrlat_top i_rrlat_top (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .link_sck    (link_sck),
        .cmd_valid   (cmd_valid),
        .cmd_class   (cmd_class),
        .cmd_opcode  (cmd_opcode),
        .soft_reset  (soft_reset),
        .dummy_count (dummy_count),
        .data_ready  (data_ready)
    );
    rrlat_host_model i_rrlat_host_model (.run(run), .sck(link_sck));
    task cmp(input string n, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer, bounded wait on pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (i >= 50) begin num_errors++; report_and_stop; end
    endtask
    // one command; for a nonzero non-legacy count the link clock runs and its rises are counted until data is ready
    task cmd(input logic [2:0] c, input logic [7:0] op, input logic [5:0] e, input logic r);
        int   i, n;
        logic prev;
        @(posedge pclk);
        {cmd_valid, cmd_class, cmd_opcode} <= {1'b1, c, op};
        @(posedge pclk);
        cmd_valid <= 1'b0;
        run <= (op != 8'hf0) && (e != 0);
        @(negedge pclk);
        cmp("dummy", e, dummy_count);
        cmp("reset", r, soft_reset);
        cmp("ready", (op != 8'hf0) && (e == 0), data_ready);
        i = 0;
        n = 0;
        prev = link_sck;
        while (run && data_ready !== 1'b1 && i < 2000) begin
            @(negedge pclk);
            i++;
            if (link_sck === 1'b1 && prev === 1'b0) n++;
            prev = link_sck;
        end
        @(posedge pclk);
        run <= 1'b0;
        if (e != 0) cmp("rises", e, n);
        if (i >= 2000) begin num_errors++; report_and_stop; end
    endtask
    task t_reset;
        apb(0, 8'h00, 0);
        cmp("nv", 0, rd);
        cmp("slverr", 0, er);
        apb(0, 8'h08, 0);
        cmp("code", 0, rd);
        apb(0, 8'h04, 0);
        cmp("v", 0, rd);
        apb(0, 8'h10, 0);
        cmp("slverr", 1, er);
        $display("reset done");
    endtask
    task t_legacy;
        cmd(0, 8'hf0, 0, 0);
        apb(1, 8'h04, 1);
        apb(1, 8'h00, 1);
        apb(0, 8'h00, 0);
        cmp("nv", 1, rd);
        apb(0, 8'h04, 0);
        cmp("v", 1, rd);
        cmd(0, 8'hf0, 0, 1);
        cmd(1, 8'h05, 0, 0);
        $display("legacy done");
    endtask
    task t_code;
        logic [5:0] e;
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'h08, k);
            apb(0, 8'h08, 0);
            cmp("code", k, rd);
            for (int c = 0; c < 4; c++) begin
                e = (k == 3) ? 2 : (k == 2 || (k == 1 && c > 0));
                cmd(c, 8'h05, e, 0);
            end
        end
        cmd(4, 8'h05, 8, 0);
        cmd(5, 8'h05, 32, 0);
        apb(0, 8'h0c, 0);
        cmp("status", 0, rd);
        $display("latency done");
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_legacy;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_code;
        report_and_stop;
    end
endmodule
`default_nettype wire
